// *** pkg/mace_pkg.sv ***
/*
 Package for the multiply-accumulate engine: widths, reset values,
 command encodings, operand and result carriers, latency counts.
 Assumes a single core clock and a core that issues one command at a time.
*/
// Notes on behaviour
// - 16x16 product added by 40-bit adder into accumulator
// - accumulate or multiply only, integer or fractional
// - signed operands, result within two clocks
// - rounded 16-bit fractional result one cycle later
// - one-bit arithmetic shift of accumulator, one clock
package mace_pkg;
   localparam int OPW = 16;                         // operand width
   localparam int ACCW = 40;                        // accumulator width
   localparam int PRODW = 32;                       // full product width
   localparam logic [ACCW-1:0] ACC_RESET = 40'h00_0000_0000;
   localparam logic [OPW-1:0] RND_RESET = 16'h0000;
   localparam int MUL_LATENCY = 2;                  // cycles to accumulator update
   localparam int RND_LATENCY = 3;                  // cycles to rounded result

   // commands issued by the core
   typedef enum logic [2:0] {
      MACE_CMD_NONE,
      MACE_CMD_MAC,
      MACE_CMD_MUL,
      MACE_CMD_SHL,
      MACE_CMD_SHR,
      MACE_CMD_CLR
   } mace_cmd_t;

   // one request from the core
   typedef struct packed {
      mace_cmd_t        cmd;
      logic             frac;     // fractional mode
      logic [OPW-1:0]   op_a;
      logic [OPW-1:0]   op_b;
   } mace_req_t;

   // results returned to the core
   typedef struct packed {
      logic [ACCW-1:0]  acc;
      logic [OPW-1:0]   rounded;
      logic             done;     // accumulator updated this cycle
      logic             rnd_done; // rounded value fresh this cycle
      logic             busy;
   } mace_rsp_t;
endpackage : mace_pkg

// *** core/mace_engine.sv ***
/*
 Multiply-accumulate engine datapath: two-stage multiply then add,
 one-cycle shifter, rounding stage one cycle after the accumulator.
 Stage one registers the signed 16x16 product; stage two adds it into
 the 40-bit accumulator or loads it; the rounding stage then takes the
 upper half of the accumulator's low 32 bits, bits 31:16, rounded to nearest.
 Assumes requests come from logic on the same clock, so no synchroniser,
 and that the core waits while busy; requests during busy are ignored.
 Assumes the clock enable is driven on the same clock; while it is low
 every register, pulses included, holds its value.
*/
`timescale 1ns/100ps
`default_nettype none
module mace_engine
   import mace_pkg::*;
(
   // clock and reset
   input  wire logic      clock,
   input  wire logic      arst_n,
   input  wire logic      clk_en,
   // request from the core
   input  wire logic      req_valid,
   input  wire mace_req_t req,
   // answer to the core
   output var  mace_rsp_t rsp
);
   // stage one: registered product and command
   logic                  s1_vld_reg, s1_vld_next;
   mace_cmd_t             s1_cmd_reg, s1_cmd_next;
   logic [PRODW-1:0]      prod_reg,   prod_next;
   // stage two: accumulator and flags
   logic [ACCW-1:0]       acc_reg,    acc_next;
   logic                  done_reg,   done_next;
   logic                  rpend_reg,  rpend_next;   // rounding pending
   logic [OPW-1:0]        rnd_reg,    rnd_next;
   logic                  rdone_reg,  rdone_next;
   // combinational helpers
   logic signed [PRODW-1:0] prod_s;     // raw signed product of this request
   logic [ACCW-1:0]       prod_ext;     // stage-one product, sign-extended
   logic [ACCW-1:0]       rnd_sum;      // accumulator plus half an lsb
   // request accepted at this edge
   logic                  take;

   // busy while a multiply is in stage one; shifts are single-cycle
   assign take = req_valid && !s1_vld_reg;

   // next-state logic for both stages
   always_comb begin
      // defaults: hold every value, pulses drop
      s1_vld_next = 1'b0;
      s1_cmd_next = s1_cmd_reg;
      prod_next   = prod_reg;
      acc_next    = acc_reg;                        // hold by default
      done_next   = 1'b0;
      rpend_next  = 1'b0;
      rnd_next    = rnd_reg;
      rdone_next  = 1'b0;
      // signed 16x16 product, doubled in fractional mode
      // operands are used only at the take edge; the core may change
      // them freely once the request is accepted
      prod_s   = $signed(req.op_a) * $signed(req.op_b);
      prod_ext = {{(ACCW-PRODW){prod_reg[PRODW-1]}}, prod_reg};
      // round to nearest at bit 15, take bits 31:16
      // no saturation: a sum past the Q31 range wraps in the result
      rnd_sum  = acc_reg + 40'h00_0000_8000;
      // first cycle: decode at most one command per enabled edge
      if (take) begin
         case (req.cmd)
            MACE_CMD_MAC, MACE_CMD_MUL: begin
               s1_vld_next = 1'b1;
               s1_cmd_next = req.cmd;
               // doubling drops the redundant sign bit for Q15 operands
               prod_next   = req.frac ? PRODW'(prod_s <<< 1) : PRODW'(prod_s);
            end
            MACE_CMD_SHL: begin
               acc_next  = {acc_reg[ACCW-2:0], 1'b0};
               done_next = 1'b1;
            end
            MACE_CMD_SHR: begin
               acc_next  = {acc_reg[ACCW-1], acc_reg[ACCW-1:1]};
               done_next = 1'b1;
            end
            MACE_CMD_CLR: begin
               acc_next  = ACC_RESET;
               done_next = 1'b1;
            end
            default: begin
               // no command: nothing changes
            end
         endcase
      end
      // stage two never meets a same-edge shift: take is low while busy
      // second cycle: add into 40-bit accumulator or load
      if (s1_vld_reg) begin
         acc_next   = (s1_cmd_reg == MACE_CMD_MAC) ? ACCW'(acc_reg + prod_ext) : prod_ext;
         done_next  = 1'b1;
         rpend_next = 1'b1;
      end
      // only multiplies arm the rounding stage; shifts and clears do not
      // third cycle: rounded fractional word
      if (rpend_reg) begin
         rnd_next   = rnd_sum[31:16];
         rdone_next = 1'b1;
      end
   end

   // registers, frozen while the clock enable is low
   // pulses freeze too, so a done seen while frozen stays high
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_vld_reg <= 1'b0;
         s1_cmd_reg <= MACE_CMD_NONE;
         prod_reg   <= '0;
         acc_reg    <= ACC_RESET;
         done_reg   <= 1'b0;
         rpend_reg  <= 1'b0;
         rnd_reg    <= RND_RESET;
         rdone_reg  <= 1'b0;
      end else if (clk_en) begin
         s1_vld_reg <= s1_vld_next;
         s1_cmd_reg <= s1_cmd_next;
         prod_reg   <= prod_next;
         acc_reg    <= acc_next;
         done_reg   <= done_next;
         rpend_reg  <= rpend_next;
         rnd_reg    <= rnd_next;
         rdone_reg  <= rdone_next;
      end
   end

   // outputs straight from flip-flops
   // one aggregate assignment keeps a single driver on the port
   assign rsp = '{acc:      acc_reg,
                  rounded:  rnd_reg,
                  done:     done_reg,
                  rnd_done: rdone_reg,
                  busy:     s1_vld_reg};

   // properties count enabled edges only; a frozen edge is not a step
   // a multiply or accumulate accepted from the core
   sequence seq_mul_issue;
      take && (req.cmd == MACE_CMD_MAC || req.cmd == MACE_CMD_MUL) && clk_en;
   endsequence
   // the enabled edge at which stage two writes the accumulator
   sequence seq_stage_two;
      s1_vld_reg && clk_en;
   endsequence
   // the enabled edge at which the rounding stage loads
   sequence seq_round;
      rpend_reg && clk_en;
   endsequence

   // done follows the take by two enabled edges
   AST_MUL_TWO: assert property (@(posedge clock) disable iff (!arst_n)
      seq_mul_issue ##1 seq_stage_two |=> done_reg)
      else $error("multiply did not finish in two cycles");

   // the rounded word follows on the third enabled edge
   AST_RND_NEXT: assert property (@(posedge clock) disable iff (!arst_n)
      seq_mul_issue ##1 seq_stage_two ##1 seq_round |=> rdone_reg)
      else $error("rounded value not one cycle after accumulate");

   // left shift brings in a zero
   AST_SHL: assert property (@(posedge clock) disable iff (!arst_n)
      (take && req.cmd == MACE_CMD_SHL && clk_en) |=>
      acc_reg == {$past(acc_reg[ACCW-2:0]), 1'b0})
      else $error("left shift wrong");

   // right shift keeps the sign bit
   AST_SHR: assert property (@(posedge clock) disable iff (!arst_n)
      (take && req.cmd == MACE_CMD_SHR && clk_en) |=>
      acc_reg[ACCW-1] == $past(acc_reg[ACCW-1]) &&
      acc_reg[ACCW-2:0] == $past(acc_reg[ACCW-1:1]))
      else $error("right shift wrong");

   // a shift finishes at the very next enabled edge
   AST_SHIFT_DONE: assert property (@(posedge clock) disable iff (!arst_n)
      (take && (req.cmd == MACE_CMD_SHL || req.cmd == MACE_CMD_SHR) && clk_en) |=> done_reg)
      else $error("shift did not finish in one cycle");

   // the accumulator moves only together with a done pulse
   AST_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
      (!done_reg) |-> $stable(acc_reg))
      else $error("accumulator changed without an operation");

   // stage one never holds a product for two enabled edges
   AST_BUSY_ONE: assert property (@(posedge clock) disable iff (!arst_n)
      (s1_vld_reg && clk_en) |=> !s1_vld_reg)
      else $error("multiply stage held more than one cycle");

   // clear returns the accumulator to its reset value
   AST_CLR: assert property (@(posedge clock) disable iff (!arst_n)
      (take && req.cmd == MACE_CMD_CLR && clk_en) |=> acc_reg == ACC_RESET)
      else $error("clear did not zero accumulator");

   // accumulate adds the sign-extended product over all 40 bits
   AST_MAC_SUM: assert property (@(posedge clock) disable iff (!arst_n)
      (s1_vld_reg && s1_cmd_reg == MACE_CMD_MAC && clk_en) |=>
      acc_reg == ACCW'($past(acc_reg) +
                       {{(ACCW-PRODW){$past(prod_reg[PRODW-1])}}, $past(prod_reg)}))
      else $error("accumulate sum wrong");

   // multiply-only loads the sign-extended product
   AST_MUL_LOAD: assert property (@(posedge clock) disable iff (!arst_n)
      (s1_vld_reg && s1_cmd_reg == MACE_CMD_MUL && clk_en) |=>
      acc_reg == {{(ACCW-PRODW){$past(prod_reg[PRODW-1])}}, $past(prod_reg)})
      else $error("multiply-only load wrong");

   // a low clock enable freezes the datapath
   AST_FREEZE: assert property (@(posedge clock) disable iff (!arst_n)
      (!clk_en) |=> $stable(acc_reg) && $stable(s1_vld_reg) && $stable(rnd_reg))
      else $error("state moved while the clock enable was low");

   // nothing taken and nothing in flight: no done pulse follows
   AST_DONE_IDLE: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && !s1_vld_reg && !take) |=> !done_reg)
      else $error("done pulse without an operation");

   // the rounded word changes only through the rounding stage
   AST_RND_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && !rpend_reg) |=> $stable(rnd_reg) && !rdone_reg)
      else $error("rounded value changed without a multiply");
endmodule : mace_engine
`default_nettype wire

// *** bench/mace_core_model.sv ***
/* core-side model of the engine's user: one request at a time.
 Assumes the same clock as the engine; drives on the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module mace_core_model
   import mace_pkg::*;
(
   // clock and answers
   input  wire logic      clock,
   input  wire mace_rsp_t rsp,
   // request out
   output var  logic      req_valid,
   output var  mace_req_t req
);
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // held across one rising edge; impolite calls ignore busy on purpose
   // hold leaves the request up for a caller that presents another at once
   task automatic issue(input mace_cmd_t c, input logic f, input logic [15:0] a,
                        input logic [15:0] b, input logic polite, input logic hold);
      if (polite) begin
         while (rsp.busy !== 1'b0) @(negedge clock);
      end
      req_valid = 1'b1;
      req = '{cmd: c, frac: f, op_a: a, op_b: b};
      @(negedge clock);
      if (!hold) begin
         req_valid = 1'b0;
         // released operands show junk, not the last value
         req = '{cmd: MACE_CMD_NONE, frac: ~f, op_a: ~a, op_b: ~b};
      end
   endtask : issue
endmodule : mace_core_model
`default_nettype wire

// *** bench/multiply_accumulate_engine_tb.sv ***
/* self-checking bench: multiply, rounding, shifts, clear, busy refusal.
 Assumes the core model drives all requests on the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module multiply_accumulate_engine_tb;
   import mace_pkg::*;
   logic      clock = 1'b0;   // 40 MHz
   logic      arst_n = 1'b0;  // async reset
   logic      clk_en = 1'b1;  // run enable
   logic      req_valid;      // from core model
   mace_req_t req;            // request
   mace_rsp_t rsp;            // answers
   int        n_mismatch = 0; // mismatches
   int        num_checks = 0; // comparisons
   always #12.5 clock = ~clock;
   mace_core_model u_core (.clock(clock), .rsp(rsp), .req_valid(req_valid), .req(req));
   mace_engine u_dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
                      .req_valid(req_valid), .req(req), .rsp(rsp));
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one command; multiplies also judged one cycle later on the rounded value
   task automatic run(input mace_cmd_t c, input logic f, input logic [15:0] a,
                      input logic [15:0] b, input int lat, input logic [39:0] exp);
      logic [39:0] r;
      u_core.issue(c, f, a, b, 1'b1, 1'b0);
      // issue returns half a cycle after the take edge
      repeat (lat - 1) @(negedge clock);
      chk("done", 40'h1, 40'(rsp.done));
      chk("acc", exp, rsp.acc);
      if (lat == MUL_LATENCY) begin
         r = exp + 40'h8000;
         repeat (RND_LATENCY - MUL_LATENCY) @(negedge clock);
         chk("rnd_done", 40'h1, 40'(rsp.rnd_done));
         chk("rounded", 40'(r[31:16]), 40'(rsp.rounded));
      end
      // let an edge pass so the next request is not raised as this one drops
      @(negedge clock);
   endtask : run
   // accumulation past the signed 32-bit range shows the full 40-bit adder
   task automatic t_mac();
      run(MACE_CMD_MAC, 1'b0, 16'h0003, 16'hFFFB, 2, 40'hFF_FFFF_FFF1);
      run(MACE_CMD_MAC, 1'b0, 16'h7FFF, 16'h7FFF, 2, 40'h00_3FFE_FFF2);
      run(MACE_CMD_MAC, 1'b0, 16'h8000, 16'h8000, 2, 40'h00_7FFE_FFF2);
      run(MACE_CMD_MAC, 1'b0, 16'h8000, 16'h8000, 2, 40'h00_BFFE_FFF2);
   endtask : t_mac
   // fractional and plain multiply, then arithmetic shifts
   task automatic t_modes();
      run(MACE_CMD_CLR, 1'b0, 16'h0000, 16'h0000, 1, 40'h00_0000_0000);
      run(MACE_CMD_MUL, 1'b1, 16'h4000, 16'h4000, 2, 40'h00_2000_0000);
      run(MACE_CMD_MAC, 1'b1, 16'hC000, 16'h4000, 2, 40'h00_0000_0000);
      run(MACE_CMD_MUL, 1'b0, 16'hFFFF, 16'h0002, 2, 40'hFF_FFFF_FFFE);
      run(MACE_CMD_SHR, 1'b0, 16'h0000, 16'h0000, 1, 40'hFF_FFFF_FFFF);
      run(MACE_CMD_SHL, 1'b0, 16'h0000, 16'h0000, 1, 40'hFF_FFFF_FFFE);
   endtask : t_modes
   // a second multiply while busy must be dropped
   task automatic t_busy();
      u_core.issue(MACE_CMD_MUL, 1'b0, 16'h0002, 16'h0003, 1'b1, 1'b1);
      chk("busy", 40'h1, 40'(rsp.busy));
      u_core.issue(MACE_CMD_MUL, 1'b0, 16'h0005, 16'h0005, 1'b0, 1'b0);
      chk("acc", 40'h6, rsp.acc);
      repeat (3) @(negedge clock);
      chk("acc held", 40'h6, rsp.acc);
      chk("done idle", 40'h0, 40'(rsp.done));
      chk("busy idle", 40'h0, 40'(rsp.busy));
   endtask : t_busy
   // a low clock enable stalls a multiply in flight, which then completes
   task automatic t_freeze();
      u_core.issue(MACE_CMD_MUL, 1'b0, 16'h0003, 16'h0003, 1'b1, 1'b0);
      clk_en = 1'b0;
      repeat (3) @(negedge clock);
      chk("busy frozen", 40'h1, 40'(rsp.busy));
      chk("acc frozen", 40'h6, rsp.acc);
      clk_en = 1'b1;
      @(negedge clock);
      chk("done after thaw", 40'h1, 40'(rsp.done));
      chk("acc after thaw", 40'h9, rsp.acc);
      @(negedge clock);
   endtask : t_freeze
   // reset in mid-run clears all, then accumulation starts afresh
   task automatic t_reset();
      arst_n = 1'b0;
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      chk("acc after reset", ACC_RESET, rsp.acc);
      chk("rounded after reset", 40'(RND_RESET), 40'(rsp.rounded));
      chk("busy after reset", 40'h0, 40'(rsp.busy));
      run(MACE_CMD_MAC, 1'b0, 16'h0002, 16'h0002, 2, 40'h00_0000_0004);
   endtask : t_reset
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   initial begin
      repeat (8) @(negedge clock);
      arst_n = 1'b1;
      chk("acc reset", 40'h0, rsp.acc);
      t_mac();
      t_modes();
      t_busy();
      t_freeze();
      t_reset();
      results();
   end
   // watchdog: the run needs about 60 cycles; 500 leaves ample room
   initial begin
      #(25 * 500);
      n_mismatch++;
      results();
   end
endmodule : multiply_accumulate_engine_tb
`default_nettype wire
